// ---- rtl/serial_port.v ----
// Full-duplex asynchronous serial port with status flags, error interrupts and data buffer.
`timescale 1ns/1ps
`include "serial_port_defs.vh"
`default_nettype none

module serial_port #(
    parameter DIV_WIDTH = 8
) (
    input wire clk,
    input wire nrst,
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [7:0] rdata,
    input wire rxd,
    output reg txd,
    output reg irq
);

    localparam RX_IDLE = 3'b001;
    localparam RX_START = 3'b010;
    localparam RX_BITS = 3'b100;
    localparam TX_IDLE = 2'b01;
    localparam TX_SEND = 2'b10;

    // ****************************************
    // Software-visible registers
    // ****************************************
    reg [DIV_WIDTH-1:0] baud_div_reg;
    reg [7:0] control_two_reg;
    reg [7:0] frame_control_reg;
    reg [4:0] error_control_reg;
    reg [7:0] rx_buf_reg;
    reg [7:0] tx_buf_reg;
    reg tx_full_reg;
    reg tx_buffer_empty_flag_reg, tc_reg, rx_buffer_full_flag_reg, idle_reg, or_reg, nf_reg, fe_reg, pf_reg;
    reg [7:0] seen_reg;

    wire long_char = frame_control_reg[`FC_LONG_CHAR];
    wire quiet_sel = frame_control_reg[`FC_QUIET_SELECT];
    wire parity_on = frame_control_reg[`FC_PARITY_ON];
    wire parity_odd = frame_control_reg[`FC_PARITY_ODD];
    wire tx_on = control_two_reg[`C2_TX_ON];
    wire rx_on = control_two_reg[`C2_RX_ON];
    wire [3:0] char_bits = long_char ? `CHAR_BITS_LONG : `CHAR_BITS_SHORT;
    wire [3:0] data_bits = long_char ? `DATA_BITS_LONG : `DATA_BITS_SHORT;

    wire [7:0] status = {tx_buffer_empty_flag_reg, tc_reg, rx_buffer_full_flag_reg, idle_reg, or_reg, nf_reg, fe_reg, pf_reg};

    // Bus decode; each access is a single-cycle strobe.
    wire status_rd = rd_en && (addr == `ADDR_STATUS);
    wire data_rd = rd_en && (addr == `ADDR_DATA);
    wire data_wr = wr_en && (addr == `ADDR_DATA);
    wire c2_wr = wr_en && (addr == `ADDR_CONTROL_TWO);
    wire preamble_q = c2_wr && wdata[`C2_TX_ON] && !tx_on;
    wire break_q = c2_wr && wdata[`C2_SEND_BREAK];

    // ****************************************
    // Shared baud generator
    // ****************************************
    reg [DIV_WIDTH-1:0] baud_cnt_reg;
    reg tick_reg;

    // One oversample tick every divisor bus clocks; a zero divisor halts both directions.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            baud_cnt_reg <= {DIV_WIDTH{1'b0}};
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= 1'b0;
            if (baud_div_reg == {DIV_WIDTH{1'b0}}) begin
                baud_cnt_reg <= {DIV_WIDTH{1'b0}};
            end else if (baud_cnt_reg >= baud_div_reg - 1'b1) begin
                baud_cnt_reg <= {DIV_WIDTH{1'b0}};
                tick_reg <= 1'b1;
            end else begin
                baud_cnt_reg <= baud_cnt_reg + 1'b1;
            end
        end
    end

    // ****************************************
    // Receiver
    // ****************************************
    reg [2:0] rx_state_reg;
    reg [3:0] rx_phase_reg;
    reg [3:0] rx_idx_reg;
    reg [8:0] rx_shift_reg;
    reg [4:0] rx_samp_reg;
    reg rx_noise_reg;
    reg [3:0] quiet_cnt_reg;
    reg idle_armed_reg;
    reg rx_done;
    reg rx_frame_err;
    reg quiet_inc;
    reg quiet_clr;

    wire maj = (rx_samp_reg[3] & rx_samp_reg[4]) | (rx_samp_reg[3] & rxd) | (rx_samp_reg[4] & rxd);
    wire bit_noise = (rx_samp_reg[3] != rxd) || (rx_samp_reg[4] != rxd);
    wire start_noise = bit_noise || (rx_samp_reg[2:0] != {3'b000}) || rxd;
    wire [7:0] rx_byte = long_char ? rx_shift_reg[7:0] : rx_shift_reg[8:1];
    wire rx_par = long_char ? ^rx_shift_reg : ^rx_shift_reg[8:1];

    // Frame walk at 16 ticks per bit; value is the majority of ticks 8, 9 and 10.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_state_reg <= RX_IDLE;
            rx_phase_reg <= 4'h0;
            rx_idx_reg <= 4'h0;
            rx_shift_reg <= 9'h000;
            rx_samp_reg <= 5'h00;
            rx_noise_reg <= 1'b0;
        end else if (!rx_on) begin
            rx_state_reg <= RX_IDLE;
            rx_phase_reg <= 4'h0;
        end else if (tick_reg) begin
            rx_phase_reg <= rx_phase_reg + 1'b1;
            if (rx_phase_reg == `PHASE_S3) rx_samp_reg[0] <= rxd;
            if (rx_phase_reg == `PHASE_S5) rx_samp_reg[1] <= rxd;
            if (rx_phase_reg == `PHASE_S7) rx_samp_reg[2] <= rxd;
            if (rx_phase_reg == `PHASE_S8) rx_samp_reg[3] <= rxd;
            if (rx_phase_reg == `PHASE_S9) rx_samp_reg[4] <= rxd;
            case (rx_state_reg)
                RX_IDLE: begin
                    if (!rxd) begin
                        rx_state_reg <= RX_START;
                        rx_phase_reg <= 4'h1;
                    end
                end
                RX_START: begin
                    if (rx_phase_reg == `PHASE_S10) begin
                        if (maj) begin
                            rx_state_reg <= RX_IDLE; // A glitch, not a start bit.
                        end else begin
                            rx_state_reg <= RX_BITS;
                            rx_idx_reg <= 4'h0;
                            rx_noise_reg <= start_noise;
                        end
                    end
                end
                RX_BITS: begin
                    if (rx_phase_reg == `PHASE_S10) begin
                        rx_noise_reg <= rx_noise_reg | bit_noise;
                        if (rx_idx_reg < data_bits) begin
                            rx_shift_reg <= {maj, rx_shift_reg[8:1]};
                            rx_idx_reg <= rx_idx_reg + 1'b1;
                        end else begin
                            rx_state_reg <= RX_IDLE;
                        end
                    end
                end
                default: rx_state_reg <= RX_IDLE;
            endcase
        end
    end

    // Stop-bit decision, plus the bit times that feed the quiet-line counter.
    always @* begin
        rx_done = 1'b0;
        rx_frame_err = 1'b0;
        quiet_inc = 1'b0;
        quiet_clr = 1'b0;
        if (rx_on && tick_reg) begin
            if (rx_state_reg == RX_IDLE) begin
                quiet_clr = !rxd;
                quiet_inc = rxd && (rx_phase_reg == `PHASE_LAST);
            end else if (rx_state_reg == RX_START) begin
                quiet_clr = 1'b1;
            end else if (rx_state_reg == RX_BITS && rx_phase_reg == `PHASE_S10) begin
                quiet_inc = maj && !quiet_sel;
                quiet_clr = !maj || quiet_sel;
                if (rx_idx_reg >= data_bits) begin
                    rx_done = 1'b1;
                    rx_frame_err = !maj;
                end
            end
        end
    end

    // Counts high bit times; the flag fires once after received data, then waits for the next character.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            quiet_cnt_reg <= 4'h0;
        end else if (quiet_clr) begin
            quiet_cnt_reg <= 4'h0;
        end else if (quiet_inc && quiet_cnt_reg < char_bits) begin
            quiet_cnt_reg <= quiet_cnt_reg + 1'b1;
        end
    end

    wire idle_set = quiet_inc && !quiet_clr && idle_armed_reg && (quiet_cnt_reg == char_bits - 1'b1);
    wire rx_load = rx_done && !rx_buffer_full_flag_reg;
    wire rx_overrun = rx_done && rx_buffer_full_flag_reg;

    // ****************************************
    // Transmitter
    // ****************************************
    reg [1:0] tx_state_reg;
    reg [3:0] tx_phase_reg;
    reg [3:0] tx_left_reg;
    reg [10:0] tx_shift_reg;
    reg pre_pend_reg;
    reg brk_pend_reg;

    // Parity, when enabled, takes the place of the last data bit.
    wire [8:0] tx_data9 = long_char ?
        {(parity_on ? (^tx_buf_reg) ^ parity_odd : 1'b0), tx_buf_reg} :
        {1'b0, (parity_on ? (^tx_buf_reg[6:0]) ^ parity_odd : tx_buf_reg[7]), tx_buf_reg[6:0]};
    wire [10:0] tx_frame = long_char ? {1'b1, tx_data9, 1'b0} : {2'b11, tx_data9[7:0], 1'b0};
    wire tx_idle = (tx_state_reg == TX_IDLE);
    wire tx_xfer = tx_idle && tx_on && tx_full_reg && !brk_pend_reg && !pre_pend_reg;

    // Break wins over preamble, preamble over data, so queued line states go out first.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_state_reg <= TX_IDLE;
            tx_phase_reg <= 4'h0;
            tx_left_reg <= 4'h0;
            tx_shift_reg <= 11'h7ff;
            pre_pend_reg <= 1'b0;
            brk_pend_reg <= 1'b0;
        end else begin
            if (preamble_q) pre_pend_reg <= 1'b1;
            if (break_q) brk_pend_reg <= 1'b1;
            case (tx_state_reg)
                TX_IDLE: begin
                    tx_shift_reg <= 11'h7ff;
                    tx_phase_reg <= 4'h0;
                    tx_left_reg <= char_bits;
                    if (tx_on && brk_pend_reg) begin
                        tx_state_reg <= TX_SEND;
                        tx_shift_reg <= 11'h000;
                        brk_pend_reg <= break_q;
                    end else if (tx_on && pre_pend_reg) begin
                        tx_state_reg <= TX_SEND;
                        pre_pend_reg <= preamble_q;
                    end else if (tx_xfer) begin
                        tx_state_reg <= TX_SEND;
                        tx_shift_reg <= tx_frame;
                    end
                end
                TX_SEND: begin
                    if (tick_reg) begin
                        tx_phase_reg <= tx_phase_reg + 1'b1;
                        if (tx_phase_reg == `PHASE_LAST) begin
                            tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                            tx_left_reg <= tx_left_reg - 1'b1;
                            if (tx_left_reg == 4'h1) tx_state_reg <= TX_IDLE;
                        end
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    // Idle, break and data alike pass through the polarity flip.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            txd <= 1'b1;
        end else begin
            txd <= tx_shift_reg[0] ^ error_control_reg[`EC_TX_POLARITY_INVERT];
        end
    end

    wire tc_set = tx_buffer_empty_flag_reg && !tx_full_reg && tx_idle && !pre_pend_reg && !brk_pend_reg &&
        !data_wr && !preamble_q && !break_q;

    // ****************************************
    // Flags and register writes
    // ****************************************
    // A flag is cleared only by the access that follows a status read which saw it set;
    // a hardware set in the same cycle wins over that clear.
    wire rx_clr = data_rd;
    wire tc_clr = (data_wr || preamble_q || break_q) && seen_reg[`ST_TC];

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            baud_div_reg <= {DIV_WIDTH{1'b0}};
            control_two_reg <= `RST_CONTROL_TWO;
            frame_control_reg <= `RST_FRAME_CONTROL;
            error_control_reg <= 5'h00;
            rx_buf_reg <= `RST_DATA;
            tx_buf_reg <= `RST_DATA;
            tx_full_reg <= 1'b0;
            tx_buffer_empty_flag_reg <= 1'b1;
            tc_reg <= 1'b1;
            rx_buffer_full_flag_reg <= 1'b0;
            idle_reg <= 1'b0;
            or_reg <= 1'b0;
            nf_reg <= 1'b0;
            fe_reg <= 1'b0;
            pf_reg <= 1'b0;
            seen_reg <= 8'h00;
            idle_armed_reg <= 1'b0;
        end else begin
            if (wr_en && addr == `ADDR_BAUD_DIVISOR) baud_div_reg <= wdata[DIV_WIDTH-1:0];
            if (c2_wr) control_two_reg <= wdata;
            if (wr_en && addr == `ADDR_FRAME_CONTROL) frame_control_reg <= wdata;
            if (wr_en && addr == `ADDR_ERROR_CONTROL) error_control_reg <= wdata[4:0];
            if (data_wr) begin
                tx_buf_reg <= wdata;
                tx_full_reg <= 1'b1;
            end else if (tx_xfer) begin
                tx_full_reg <= 1'b0;
            end
            tx_buffer_empty_flag_reg <= tx_xfer | (tx_buffer_empty_flag_reg & ~(data_wr & seen_reg[`ST_TX_BUFFER_EMPTY_FLAG]));
            tc_reg <= tc_set | (tc_reg & ~tc_clr);
            if (rx_load) rx_buf_reg <= rx_byte;
            rx_buffer_full_flag_reg <= rx_load | (rx_buffer_full_flag_reg & ~(rx_clr & seen_reg[`ST_RX_BUFFER_FULL_FLAG]));
            nf_reg <= (rx_load & rx_noise_reg) | (nf_reg & ~(rx_clr & seen_reg[`ST_NF]));
            fe_reg <= (rx_load & rx_frame_err) | (fe_reg & ~(rx_clr & seen_reg[`ST_FE]));
            pf_reg <= (rx_load & parity_on & (rx_par != parity_odd)) | (pf_reg & ~(rx_clr & seen_reg[`ST_PF]));
            or_reg <= rx_overrun | (or_reg & ~(rx_clr & seen_reg[`ST_OR]));
            idle_reg <= idle_set | (idle_reg & ~(rx_clr & seen_reg[`ST_IDLE]));
            if (rx_load) begin
                idle_armed_reg <= 1'b1;
            end else if (idle_set) begin
                idle_armed_reg <= 1'b0;
            end
            if (status_rd) begin
                seen_reg <= status;
            end else begin
                if (data_rd) seen_reg[5:0] <= 6'h00;
                if (data_wr) seen_reg[7:6] <= 2'b00;
                if (preamble_q || break_q) seen_reg[`ST_TC] <= 1'b0;
            end
        end
    end

    // ****************************************
    // Read port and interrupt request
    // ****************************************
    // Read data stand only in the cycle after the strobe; unmapped offsets read zero.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (rd_en) begin
            case (addr)
                `ADDR_BAUD_DIVISOR: rdata <= baud_div_reg;
                `ADDR_CONTROL_TWO: rdata <= control_two_reg;
                `ADDR_FRAME_CONTROL: rdata <= frame_control_reg;
                `ADDR_STATUS: rdata <= status;
                `ADDR_ERROR_CONTROL: rdata <= {3'b000, error_control_reg};
                `ADDR_DATA: rdata <= rx_buf_reg;
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // One level request, held while any enabled error flag stays set.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= (or_reg & error_control_reg[`EC_OVERRUN_IRQ_ENABLE]) |
                (nf_reg & error_control_reg[`EC_NOISE_IRQ_ENABLE]) |
                (fe_reg & error_control_reg[`EC_FRAMING_IRQ_ENABLE]) |
                (pf_reg & error_control_reg[`EC_PARITY_IRQ_ENABLE]);
        end
    end

endmodule

`default_nettype wire

// ---- pkg/serial_port_defs.vh ----
// Register map, field positions, reset values and bit-timing counts of the serial port.
`ifndef SERIAL_PORT_DEFS_VH
`define SERIAL_PORT_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_BAUD_DIVISOR 3'h0
`define ADDR_CONTROL_TWO 3'h1
`define ADDR_FRAME_CONTROL 3'h2
`define ADDR_STATUS 3'h3
`define ADDR_ERROR_CONTROL 3'h4
`define ADDR_DATA 3'h5

// ****************************************
// Reset values
// ****************************************
`define RST_BAUD_DIVISOR 8'h00
`define RST_CONTROL_TWO 8'h00
`define RST_FRAME_CONTROL 8'h00
`define RST_ERROR_CONTROL 8'h00
`define RST_DATA 8'h00

// ****************************************
// Status register fields
// ****************************************
`define ST_TX_BUFFER_EMPTY_FLAG 7
`define ST_TC 6
`define ST_RX_BUFFER_FULL_FLAG 5
`define ST_IDLE 4
`define ST_OR 3
`define ST_NF 2
`define ST_FE 1
`define ST_PF 0

// ****************************************
// Control fields
// ****************************************
`define EC_TX_POLARITY_INVERT 4
`define EC_OVERRUN_IRQ_ENABLE 3
`define EC_NOISE_IRQ_ENABLE 2
`define EC_FRAMING_IRQ_ENABLE 1
`define EC_PARITY_IRQ_ENABLE 0
`define C2_TX_ON 3
`define C2_RX_ON 2
`define C2_SEND_BREAK 0
`define FC_LONG_CHAR 4
`define FC_QUIET_SELECT 2
`define FC_PARITY_ON 1
`define FC_PARITY_ODD 0

// ****************************************
// Bit timing: sample phases in oversample ticks, character and data lengths in bits
// ****************************************
`define PHASE_LAST 4'hf
`define PHASE_S3 4'h3
`define PHASE_S5 4'h5
`define PHASE_S7 4'h7
`define PHASE_S8 4'h8
`define PHASE_S9 4'h9
`define PHASE_S10 4'ha
`define CHAR_BITS_SHORT 4'ha
`define CHAR_BITS_LONG 4'hb
`define DATA_BITS_SHORT 4'h8
`define DATA_BITS_LONG 4'h9

`endif

// ---- verif/serial_port_assertions.sv ----
// Checker for the serial port register answers and the interrupt request level.
`timescale 1ns/1ps
`default_nettype none
module serial_port_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic rxd,
    input wire logic txd,
    input wire logic irq
);
    // ****************************************
    // Shadow state and properties
    // ****************************************
    logic [4:0] en_reg;
    logic [4:0] en_prev_reg;
    logic rd_reg;
    logic [2:0] addr_reg;
    wire st_seen = rd_reg && addr_reg == 3'h3;
    // The enables are shadowed from the bus, so the request level can be predicted from a status answer.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            en_reg <= 5'h00;
            en_prev_reg <= 5'h00;
            rd_reg <= 1'b0;
            addr_reg <= 3'h0;
        end else begin
            if (wr_en && addr == 3'h4) en_reg <= wdata[4:0];
            en_prev_reg <= en_reg;
            rd_reg <= rd_en;
            addr_reg <= addr;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    rdata_stand_a: assert property (!rd_reg |-> rdata == 8'h00)
        else $error("read data not zero outside the answer cycle");
    unmapped_read_a: assert property (rd_reg && addr_reg > 3'h5 |-> rdata == 8'h00)
        else $error("unmapped offset read not zero");
    enable_readback_a: assert property (rd_reg && addr_reg == 3'h4 |-> rdata == {3'h0, en_prev_reg})
        else $error("error control read back differs from written value");
    tc_needs_empty_a: assert property (st_seen && rdata[6] |-> rdata[7])
        else $error("transmit complete without empty buffer");
    noise_with_full_a: assert property (st_seen && rdata[2] |-> rdata[5])
        else $error("noise flag without receive full");
    irq_raise_a: assert property (st_seen && (rdata[3:0] & en_prev_reg[3:0]) != 4'h0 |-> irq)
        else $error("enabled flag set but no interrupt request");
    irq_quiet_a: assert property (st_seen && (rdata[3:0] & en_prev_reg[3:0]) == 4'h0 |-> !irq)
        else $error("interrupt request without an enabled flag");
    irq_masked_a: assert property (wr_en && addr == 3'h4 && wdata[3:0] == 4'h0 |-> ##2 !irq)
        else $error("interrupt request stays after enables cleared");
    // Main scenarios that the bench should reach.
    irq_seen_c: cover property ($rose(irq));
    full_seen_c: cover property (st_seen && rdata[5]);
    overrun_seen_c: cover property (st_seen && rdata[3]);
endmodule
bind serial_port serial_port_checker chk_i (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rxd(rxd), .txd(txd), .irq(irq));
`default_nettype wire

// ---- verif/serial_remote.sv ----
// Remote serial device model: sends frames on the receive line and decodes the transmit line.
`timescale 1ns/1ps
`default_nettype none
module serial_remote (
    input wire logic clk,
    input wire logic send,
    input wire logic [7:0] tx_data,
    input wire logic glitch,
    input wire logic bad_stop,
    output var logic line,
    output var logic busy,
    input wire logic txd_in,
    output var logic [7:0] rx_byte,
    output var logic [7:0] rx_count
);
    // ****************************************
    // Sender and receiver, 16 clocks per bit
    // ****************************************
    logic [9:0] frame;
    logic [7:0] shift;
    // Sends start, eight bits lowest first, then a stop bit that may be broken on request.
    initial begin
        line = 1'b1;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (send) begin
                busy <= 1'b1;
                frame = {~bad_stop, tx_data, 1'b0};
                // A one-clock spike in the first data bit upsets only one of its three samples.
                for (int i = 0; i < 160; i++) begin
                    line <= frame[i / 16] ^ (glitch && i == 25);
                    @(posedge clk);
                end
                line <= 1'b1;
                busy <= 1'b0;
            end
        end
    end
    // Decodes on the falling edge so the registered line is never read as it changes.
    initial begin
        rx_byte = 8'h00;
        rx_count = 8'h00;
        forever begin
            @(negedge clk);
            if (txd_in === 1'b0) begin
                repeat (24) @(negedge clk);
                for (int k = 0; k < 8; k++) begin
                    shift[k] = txd_in;
                    repeat (16) @(negedge clk);
                end
                rx_byte <= shift;
                rx_count <= rx_count + 8'h01;
                while (txd_in !== 1'b1) @(negedge clk);
            end
        end
    end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking testbench for the serial port status flags, interrupts and data buffer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, txd, irq, busy;
    logic nrst = 1'b0, wr_en = 1'b0, rd_en = 1'b0, send = 1'b0, glitch = 1'b0, bad_stop = 1'b0, rxd;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, tx_data = 8'h00, rdata, rx_byte, rx_count, st, cnt;
    int miscompares = 0;
    int checks_done = 0;
    serial_port uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .rxd(rxd), .txd(txd), .irq(irq));
    serial_remote far (.clk(clk), .send(send), .tx_data(tx_data), .glitch(glitch), .bad_stop(bad_stop),
        .line(rxd), .busy(busy), .txd_in(txd), .rx_byte(rx_byte), .rx_count(rx_count));
    // ****************************************
    // Clock, bus tasks and scenarios
    // ****************************************
    // A 50 ns period gives the 20 MHz bus clock.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    // The answer stands only in the cycle after the strobe, so it is taken just after that edge.
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 st = rdata;
    endtask
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic frame(input logic [7:0] d, input logic g, input logic b);
        @(posedge clk);
        tx_data <= d;
        glitch <= g;
        bad_stop <= b;
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        repeat (2) @(posedge clk);
        for (int n = 0; n < 300 && busy; n++) @(posedge clk);
        repeat (20) @(posedge clk);
    endtask
    // One received character case: flags, request level, stored byte and the clearing sequence.
    task automatic rx_case(input logic [7:0] fc, input logic [7:0] ec, input logic [7:0] d, input logic g,
        input logic b, input logic twice, input logic [7:0] exp, input logic ei);
        wr(3'h2, fc);
        wr(3'h4, ec);
        frame(d, g, b);
        if (twice) frame(~d, 1'b0, 1'b0);
        rd(3'h3);
        chk("status", st & 8'h2f, exp);
        chk("irq", {7'h00, irq}, {7'h00, ei});
        rd(3'h5);
        chk("data", st, d);
        repeat (2) @(posedge clk);
        chk("irq released", {7'h00, irq}, 8'h00);
        rd(3'h3);
        chk("cleared", st & 8'h2f, 8'h00);
    endtask
    task automatic test_done();
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // A hang is cut short well beyond the few thousand cycles the run needs.
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        test_done();
    end
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        rd(3'h3);
        chk("status reset", st, 8'hc0);
        rd(3'h5);
        chk("data reset", st, 8'h00);
        wr(3'h6, 8'hff);
        rd(3'h6);
        chk("unmapped", st, 8'h00);
        // Divisor one keeps a bit at 16 clocks; enabling the transmitter first sends a preamble.
        wr(3'h0, 8'h01);
        wr(3'h1, 8'h0c);
        repeat (200) @(posedge clk);
        rd(3'h3);
        chk("tx idle", st, 8'hc0);
        cnt = rx_count;
        wr(3'h5, 8'ha5);
        repeat (3) @(posedge clk);
        rd(3'h3);
        chk("tx busy", st & 8'hc0, 8'h80);
        for (int n = 0; n < 400 && rx_count == cnt; n++) @(posedge clk);
        chk("tx byte", rx_byte, 8'ha5);
        repeat (30) @(posedge clk);
        rd(3'h3);
        chk("tx done", st & 8'hc0, 8'hc0);
        wr(3'h1, 8'h0d);
        repeat (3) @(posedge clk);
        rd(3'h3);
        chk("break tc", st & 8'h40, 8'h00);
        chk("break line", {7'h00, txd}, 8'h00);
        repeat (250) @(posedge clk);
        wr(3'h1, 8'h04);
        rd(3'h3);
        wr(3'h1, 8'h0c);
        repeat (3) @(posedge clk);
        rd(3'h3);
        chk("preamble tc", st & 8'h40, 8'h00);
        repeat (250) @(posedge clk);
        wr(3'h4, 8'h10);
        repeat (3) @(posedge clk);
        chk("inverted idle", {7'h00, txd}, 8'h00);
        rd(3'h4);
        chk("error control", st, 8'h10);
        wr(3'h4, 8'h00);
        repeat (3) @(posedge clk);
        chk("plain idle", {7'h00, txd}, 8'h01);
        rx_case(8'h00, 8'h04, 8'h3c, 1'b1, 1'b0, 1'b0, 8'h24, 1'b1);
        rx_case(8'h00, 8'h02, 8'h5a, 1'b0, 1'b1, 1'b0, 8'h22, 1'b1);
        rx_case(8'h00, 8'h00, 8'h5a, 1'b0, 1'b1, 1'b0, 8'h22, 1'b0);
        rx_case(8'h02, 8'h01, 8'h01, 1'b0, 1'b0, 1'b0, 8'h21, 1'b1);
        rx_case(8'h00, 8'h08, 8'h11, 1'b0, 1'b0, 1'b1, 8'h28, 1'b1);
        rx_case(8'h10, 8'h00, 8'h96, 1'b0, 1'b0, 1'b0, 8'h20, 1'b0);
        rx_case(8'h03, 8'h01, 8'h01, 1'b0, 1'b0, 1'b0, 8'h20, 1'b0);
        // All-ones characters show where idle counting starts for each quiet-count setting.
        for (int q = 0; q < 2; q++) begin
            wr(3'h2, {5'h00, q[0], 2'h0});
            frame(8'hff, 1'b0, 1'b0);
            repeat (20) @(posedge clk);
            rd(3'h3);
            chk("idle early", st & 8'h30, {2'h0, 1'b1, ~q[0], 4'h0});
            rd(3'h5);
        end
        repeat (200) @(posedge clk);
        rd(3'h3);
        chk("idle set", st & 8'h10, 8'h10);
        rd(3'h5);
        repeat (400) @(posedge clk);
        rd(3'h3);
        chk("idle once", st & 8'h10, 8'h00);
        test_done();
    end
endmodule
`default_nettype wire
